//--- flash_protect_option_load.sv
// Purpose: block protect register, shared page select address, trim portal
//          and option load at reset for the program flash
// Assumes: register file port is synchronous, one access per cycle
// Notes:   option configuration registers have no register file address

module flash_protect_option_load #(
    parameter int TRIM_BYTES    = 32,
    parameter int FACTORY_BYTES = 32
) (
    input  wire logic                        clock_in,
    input  wire logic                        rstn_in,
    input  wire flash_protect_pkg::reg_req_t reg_req_in,
    output logic      [7:0]                  reg_rdata_out,
    input  wire logic [2:0]                  ctrl_state_in,
    output logic      [7:0]                  page_select_out,
    output logic      [7:0]                  protect_cfg_out,
    input  wire logic                        stop_recover_in,
    input  wire logic [7:0]                  flash_rdata_in,
    output logic                             flash_rd_out,
    output logic                             flash_info_out,
    output logic      [15:0]                 flash_addr_out,
    output logic                             cpu_run_out,
    output logic      [15:0]                 user_option_out,
    output logic      [TRIM_BYTES*8-1:0]     trim_bytes_out,
    output logic      [FACTORY_BYTES*8-1:0]  factory_bytes_out,
    input  wire logic                        info_locked_in,
    input  wire logic                        dbg_opt_wr_in,
    input  wire logic                        dbg_opt_rd_in,
    input  wire logic [4:0]                  dbg_opt_idx_in,
    input  wire logic [7:0]                  dbg_opt_data_in,
    output logic      [7:0]                  dbg_opt_rdata_out,
    input  wire logic                        pm_rd_in,
    input  wire logic [15:0]                 pm_addr_in,
    output flash_protect_pkg::region_t       pm_region_out,
    output logic      [8:0]                  pm_info_offs_out,
    input  wire flash_protect_pkg::op_req_t  op_req_in,
    output logic                             op_grant_out,
    output logic                             op_refuse_out,
    output logic                             user_option_stale_out
);
    import flash_protect_pkg::*;

    logic        protect_sel_q;
    logic [7:0]  protect_cfg_q;
    logic [7:0]  page_select_q;
    logic [7:0]  trim_index_q;
    logic [15:0] user_opt_q;
    logic        cmd_wr;
    logic        shared_wr;
    logic        trim_idx_wr;
    logic        trim_val_wr;
    logic        load_we;
    logic [6:0]  load_idx;
    logic [6:0]  load_offs;
    logic [7:0]  load_data;
    logic        load_done;
    logic        bank_we;
    logic [4:0]  bank_idx;
    logic [5:0]  op_page;
    logic        op_protected;
    logic        op_refuse_d;
    region_t     region_d;
    logic [8:0]  offs_d;
    logic [7:0]  rdata_d;

    assign cmd_wr      = reg_req_in.wr && reg_req_in.addr == ADDR_CMD_STATUS;
    assign shared_wr   = reg_req_in.wr && reg_req_in.addr == ADDR_PAGE_SHARED;
    assign trim_idx_wr = reg_req_in.wr && reg_req_in.addr == ADDR_TRIM_INDEX;
    assign trim_val_wr = reg_req_in.wr && reg_req_in.addr == ADDR_TRIM_VALUE;

    // shared address select
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            protect_sel_q <= 1'b0;
        end else if (cmd_wr) begin
            protect_sel_q <= (reg_req_in.wdata == CMD_PROTECT_SEL)
                             && (ctrl_state_in == STATE_LOCKED);
        end
    end

    // block protect register
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            protect_cfg_q <= PROTECT_RESET;
        end else if (shared_wr && protect_sel_q) begin
            if (protect_cfg_q[PROTECT_EN_BIT]) begin
                protect_cfg_q <= protect_cfg_q | (reg_req_in.wdata & SHARED_WMASK);
            end else begin
                protect_cfg_q <= reg_req_in.wdata & SHARED_WMASK;
            end
        end
    end

    // page select register
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            page_select_q <= PAGE_SELECT_RESET;
        end else if (shared_wr && !protect_sel_q) begin
            page_select_q <= reg_req_in.wdata & SHARED_WMASK;
        end
    end

    // trim index, five bits reach info 20h..3Fh only
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            trim_index_q <= TRIM_INDEX_RESET;
        end else if (trim_idx_wr) begin
            trim_index_q <= reg_req_in.wdata;
        end
    end

    // register file read data
    always_comb begin
        rdata_d = 8'h00;
        if (reg_req_in.addr == ADDR_TRIM_INDEX) begin
            rdata_d = trim_index_q;
        end else if (reg_req_in.addr == ADDR_TRIM_VALUE) begin
            rdata_d = trim_bytes_out[trim_index_q[4:0]*8 +: 8];
        end else if (reg_req_in.addr == ADDR_CMD_STATUS) begin
            rdata_d = {5'h00, protect_sel_q ? STATE_PROTECT_SEL : ctrl_state_in};
        end else if (reg_req_in.addr == ADDR_PAGE_SHARED) begin
            rdata_d = protect_sel_q ? protect_cfg_q : page_select_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_req_in.rd) begin
            reg_rdata_out <= rdata_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            page_select_out <= PAGE_SELECT_RESET;
            protect_cfg_out <= PROTECT_RESET;
        end else begin
            page_select_out <= page_select_q;
            protect_cfg_out <= protect_cfg_q;
        end
    end

    // option load from flash on reset and stop recovery
    option_loader u_loader (
        .clock_in       (clock_in),
        .rstn_in        (rstn_in),
        .restart_in     (stop_recover_in),
        .flash_rdata_in (flash_rdata_in),
        .flash_rd_out   (flash_rd_out),
        .flash_info_out (flash_info_out),
        .flash_addr_out (flash_addr_out),
        .load_we_out    (load_we),
        .load_idx_out   (load_idx),
        .load_data_out  (load_data),
        .done_out       (load_done)
    );

    // bank split from the offset past the user bytes, not from the raw index
    assign bank_we   = load_we && load_idx >= USER_OPT_BYTES;
    assign load_offs = load_idx - USER_OPT_BYTES;
    assign bank_idx  = load_offs[4:0];

    // user option bytes, only the loader writes them
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            user_opt_q <= 16'h0000;
        end else if (load_we && load_idx < USER_OPT_BYTES) begin
            user_opt_q[load_idx[0]*8 +: 8] <= load_data;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            user_option_out <= 16'h0000;
        end else begin
            user_option_out <= user_opt_q;
        end
    end

    // processor held until all options are in place
    always_ff @(posedge clock_in) begin
        if (!rstn_in || stop_recover_in) begin
            cpu_run_out <= 1'b0;
        end else begin
            cpu_run_out <= load_done && !load_we;
        end
    end

    // trim working copies, loader fills 34..65
    byte_bank #(.DEPTH(TRIM_BYTES), .WIDTH(8)) u_trim (
        .clock_in  (clock_in),
        .rstn_in   (rstn_in),
        .a_we_in   (bank_we && load_offs[5]),
        .a_idx_in  (bank_idx),
        .a_data_in (load_data),
        .b_we_in   (trim_val_wr),
        .b_idx_in  (trim_index_q[4:0]),
        .b_data_in (reg_req_in.wdata),
        .bytes_out (trim_bytes_out)
    );

    // factory option working copies, loader fills 2..33
    byte_bank #(.DEPTH(FACTORY_BYTES), .WIDTH(8)) u_factory (
        .clock_in  (clock_in),
        .rstn_in   (rstn_in),
        .a_we_in   (bank_we && !load_offs[5]),
        .a_idx_in  (bank_idx),
        .a_data_in (load_data),
        .b_we_in   (dbg_opt_wr_in && !info_locked_in),
        .b_idx_in  (dbg_opt_idx_in),
        .b_data_in (dbg_opt_data_in),
        .bytes_out (factory_bytes_out)
    );

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            dbg_opt_rdata_out <= 8'h00;
        end else if (dbg_opt_rd_in) begin
            dbg_opt_rdata_out <= factory_bytes_out[dbg_opt_idx_in*8 +: 8];
        end
    end

    // program memory view of the information area
    always_comb begin
        region_d = RGN_MAIN;
        offs_d   = 9'h000;
        if (page_select_q[INFO_SEL_BIT] && pm_addr_in >= INFO_BASE) begin
            offs_d = pm_addr_in[8:0];
            if (pm_addr_in <= FACTORY_LAST) begin
                region_d = RGN_FACTORY;
            end else if (pm_addr_in <= TRIM_LAST) begin
                region_d = RGN_TRIM;
            end else if (pm_addr_in >= DEVICE_FIRST && pm_addr_in <= DEVICE_LAST) begin
                region_d = RGN_DEVICE;
            end else begin
                region_d = RGN_INFO_OTHER;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pm_region_out    <= RGN_MAIN;
            pm_info_offs_out <= 9'h000;
        end else if (pm_rd_in) begin
            pm_region_out    <= region_d;
            pm_info_offs_out <= offs_d;
        end
    end

    // program and erase permission
    assign op_page      = op_req_in.addr[PAGE_MSB:PAGE_LSB];
    assign op_protected = protect_cfg_q[PROTECT_EN_BIT]
                          && op_page < protect_cfg_q[5:0];
    always_comb begin
        op_refuse_d = 1'b0;
        if (op_req_in.kind != OP_MASS_ERASE && op_protected) begin
            op_refuse_d = 1'b1;
        end else if (op_req_in.kind == OP_PAGE_ERASE && page_select_q[INFO_SEL_BIT]) begin
            op_refuse_d = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            op_grant_out  <= 1'b0;
            op_refuse_out <= 1'b0;
        end else begin
            op_grant_out  <= op_req_in.valid && !op_refuse_d;
            op_refuse_out <= op_req_in.valid && op_refuse_d;
        end
    end

    // flags flash user options changed since the last load
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            user_option_stale_out <= 1'b0;
        end else if (op_req_in.valid && !op_refuse_d
                     && (op_page == 6'h00 || op_req_in.kind == OP_MASS_ERASE)) begin
            user_option_stale_out <= 1'b1;
        end else if (stop_recover_in) begin
            user_option_stale_out <= 1'b0;
        end
    end

    AST_SELECT_ON_CMD: assert property (@(posedge clock_in) disable iff (!rstn_in)
        cmd_wr && reg_req_in.wdata == CMD_PROTECT_SEL && ctrl_state_in == STATE_LOCKED
        |=> protect_sel_q ##1 (protect_sel_q || $past(cmd_wr)))
        else $error("protect register not selected by command");

    AST_SHARED_READ: assert property (@(posedge clock_in) disable iff (!rstn_in)
        reg_req_in.rd && !reg_req_in.wr && reg_req_in.addr == ADDR_PAGE_SHARED
        && protect_sel_q |=> reg_rdata_out == $past(protect_cfg_q))
        else $error("shared read did not return protect register");

    AST_DESELECT: assert property (@(posedge clock_in) disable iff (!rstn_in)
        cmd_wr && reg_req_in.wdata != CMD_PROTECT_SEL |=> !protect_sel_q)
        else $error("command write did not deselect");

    AST_NO_CLEAR: assert property (@(posedge clock_in) disable iff (!rstn_in)
        protect_cfg_q[PROTECT_EN_BIT] |=> (protect_cfg_q & $past(protect_cfg_q))
        == $past(protect_cfg_q))
        else $error("protect bit cleared while enabled");

    AST_BIT6_ZERO: assert property (@(posedge clock_in) disable iff (!rstn_in)
        shared_wr |=> !protect_cfg_q[RESERVED_BIT] && !page_select_q[RESERVED_BIT])
        else $error("reserved bit 6 became set");

    AST_PROTECTED_REFUSED: assert property (@(posedge clock_in) disable iff (!rstn_in)
        op_req_in.valid && op_req_in.kind == OP_PROGRAM && protect_cfg_q[PROTECT_EN_BIT]
        && op_req_in.addr[PAGE_MSB:PAGE_LSB] < protect_cfg_q[5:0]
        |=> op_refuse_out && !op_grant_out)
        else $error("protected page operation not refused");

    AST_CPU_AFTER_LOAD: assert property (@(posedge clock_in) disable iff (!rstn_in)
        $rose(cpu_run_out) |-> load_done && $past(load_done) && !load_we)
        else $error("processor released before options loaded");

    AST_STATE_100: assert property (@(posedge clock_in) disable iff (!rstn_in)
        reg_req_in.rd && !reg_req_in.wr && reg_req_in.addr == ADDR_CMD_STATUS
        && protect_sel_q |=> reg_rdata_out == {5'h00, STATE_PROTECT_SEL})
        else $error("status did not report protect selected");

    AST_OPTION_STABLE: assert property (@(posedge clock_in) disable iff (!rstn_in)
        cpu_run_out && !stop_recover_in |=> $stable(user_opt_q))
        else $error("user options changed while running");

    AST_INFO_MAP: assert property (@(posedge clock_in) disable iff (!rstn_in)
        pm_rd_in && page_select_q[INFO_SEL_BIT] && pm_addr_in >= INFO_BASE
        |=> pm_region_out != RGN_MAIN && pm_info_offs_out == $past(pm_addr_in[8:0]))
        else $error("info area not mapped at FE00h");
endmodule

//--- flash_protect_pkg.sv
// Purpose: shared constants and types for the flash protect and option load block
// Assumes: 8-bit register file port, 16-bit program memory addresses
// Notes:   offsets are register file addresses
package flash_protect_pkg;
    localparam logic [11:0] ADDR_TRIM_INDEX   = 12'hff6;
    localparam logic [11:0] ADDR_TRIM_VALUE   = 12'hff7;
    localparam logic [11:0] ADDR_CMD_STATUS   = 12'hff8;
    localparam logic [11:0] ADDR_PAGE_SHARED  = 12'hff9;
    localparam logic [7:0]  CMD_PROTECT_SEL   = 8'h5e;
    localparam logic [2:0]  STATE_LOCKED      = 3'h0;
    localparam logic [2:0]  STATE_PROTECT_SEL = 3'h4;
    localparam logic [7:0]  PROTECT_RESET     = 8'h00;
    localparam logic [7:0]  PAGE_SELECT_RESET = 8'h00;
    localparam logic [7:0]  TRIM_INDEX_RESET  = 8'h00;
    localparam logic [7:0]  SHARED_WMASK      = 8'hbf;
    localparam int          PROTECT_EN_BIT    = 7;
    localparam int          INFO_SEL_BIT      = 7;
    localparam int          RESERVED_BIT      = 6;
    localparam int          PAGE_MSB          = 14;
    localparam int          PAGE_LSB          = 9;
    localparam logic [15:0] INFO_BASE         = 16'hfe00;
    localparam logic [15:0] FACTORY_LAST      = 16'hfe1f;
    localparam logic [15:0] TRIM_LAST         = 16'hfe3f;
    localparam logic [15:0] DEVICE_FIRST      = 16'hfe40;
    localparam logic [15:0] DEVICE_LAST       = 16'hfe57;
    localparam logic [6:0]  USER_OPT_BYTES    = 7'h02;
    localparam logic [6:0]  LOAD_LAST         = 7'h41;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;
    typedef enum logic [1:0] {OP_PROGRAM = 2'h0, OP_PAGE_ERASE = 2'h1, OP_MASS_ERASE = 2'h2} op_kind_t;
    typedef struct packed {
        logic        valid;
        op_kind_t    kind;
        logic [15:0] addr;
    } op_req_t;
    typedef enum logic [2:0] {RGN_MAIN = 3'h0, RGN_FACTORY = 3'h1, RGN_TRIM = 3'h2,
                              RGN_DEVICE = 3'h3, RGN_INFO_OTHER = 3'h4} region_t;
    typedef enum logic [1:0] {LD_ISSUE = 2'b00, LD_CAPTURE = 2'b01, LD_DONE = 2'b11} load_state_t;
endpackage

//--- byte_bank.sv
// Purpose: volatile bank of working bytes with a load port and a user port
// Assumes: load port has priority over user port
// Notes:   never written back to flash
module byte_bank #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 8
) (
    input  wire logic                      clock_in,
    input  wire logic                      rstn_in,
    input  wire logic                      a_we_in,
    input  wire logic [$clog2(DEPTH)-1:0]  a_idx_in,
    input  wire logic [WIDTH-1:0]          a_data_in,
    input  wire logic                      b_we_in,
    input  wire logic [$clog2(DEPTH)-1:0]  b_idx_in,
    input  wire logic [WIDTH-1:0]          b_data_in,
    output logic      [DEPTH*WIDTH-1:0]    bytes_out
);
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : gen_entry
            // working copy only, lost at power off
            always_ff @(posedge clock_in) begin
                if (!rstn_in) begin
                    bytes_out[g*WIDTH +: WIDTH] <= '0;
                end else if (a_we_in && a_idx_in == g) begin
                    bytes_out[g*WIDTH +: WIDTH] <= a_data_in;
                end else if (b_we_in && b_idx_in == g) begin
                    bytes_out[g*WIDTH +: WIDTH] <= b_data_in;
                end
            end
        end
    endgenerate
endmodule

//--- option_loader.sv
// Purpose: copies user options, factory options and trim bytes out of flash
// Assumes: flash_rdata_in is valid in the cycle flash_rd_out is high
// Notes:   restarts on reset and on restart_in
module option_loader (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic        restart_in,
    input  wire logic [7:0]  flash_rdata_in,
    output logic             flash_rd_out,
    output logic             flash_info_out,
    output logic      [15:0] flash_addr_out,
    output logic             load_we_out,
    output logic      [6:0]  load_idx_out,
    output logic      [7:0]  load_data_out,
    output logic             done_out
);
    import flash_protect_pkg::*;
    load_state_t state_q;
    logic [6:0]  cnt_q;

    always_ff @(posedge clock_in) begin
        if (!rstn_in || restart_in) begin
            state_q        <= LD_ISSUE;
            cnt_q          <= 7'h00;
            flash_rd_out   <= 1'b0;
            flash_info_out <= 1'b0;
            flash_addr_out <= 16'h0000;
            load_we_out    <= 1'b0;
            load_idx_out   <= 7'h00;
            load_data_out  <= 8'h00;
            done_out       <= 1'b0;
        end else begin
            case (state_q)
                LD_ISSUE: begin
                    load_we_out    <= 1'b0;
                    flash_rd_out   <= 1'b1;
                    flash_info_out <= (cnt_q >= USER_OPT_BYTES);
                    if (cnt_q < USER_OPT_BYTES) begin
                        flash_addr_out <= {9'h000, cnt_q};
                    end else begin
                        flash_addr_out <= INFO_BASE + {9'h000, cnt_q - USER_OPT_BYTES};
                    end
                    state_q <= LD_CAPTURE;
                end
                LD_CAPTURE: begin
                    flash_rd_out  <= 1'b0;
                    load_we_out   <= 1'b1;
                    load_idx_out  <= cnt_q;
                    load_data_out <= flash_rdata_in;
                    if (cnt_q == LOAD_LAST) begin
                        state_q  <= LD_DONE;
                        done_out <= 1'b1;
                    end else begin
                        cnt_q   <= cnt_q + 7'h01;
                        state_q <= LD_ISSUE;
                    end
                end
                default: begin
                    load_we_out  <= 1'b0;
                    flash_rd_out <= 1'b0;
                end
            endcase
        end
    end
endmodule

//--- flash_model.sv
// Purpose: program and information flash contents seen by the option loader
// Assumes: read data is combinational in the read cycle
// Notes:   outside read cycles the data lines show the inverse value
module flash_model (
    input  wire logic        rd_in,
    input  wire logic        info_in,
    input  wire logic [15:0] addr_in,
    output logic      [7:0]  data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] v;
    assign v = addr_in[7:0] ^ (info_in ? 8'h5a : 8'ha5);
    assign data_out = rd_in ? v : ~v;
endmodule

//--- tb.sv
// Purpose: self-checking bench for block protect, trim portal and option load
// Assumes: inputs change at the falling clock edge
// Notes:   flash byte is address low byte xor a5h (main) or 5ah (info)
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_protect_pkg::*;
    logic clock_in = 1'h0, rstn_in = 1'h0, stop_recover_in = 1'h0, info_locked_in = 1'h0;
    logic dbg_opt_wr_in = 1'h0, dbg_opt_rd_in = 1'h0, pm_rd_in = 1'h0;
    reg_req_t reg_req_in = '0;
    op_req_t op_req_in = '0;
    logic [2:0] ctrl_state_in = 3'h0;
    logic [4:0] dbg_opt_idx_in = 5'h03;
    logic [7:0] dbg_opt_data_in = 8'h00;
    logic [15:0] pm_addr_in = 16'h0000;
    logic [7:0] reg_rdata_out, page_select_out, protect_cfg_out, flash_rdata_in, dbg_opt_rdata_out;
    logic flash_rd_out, flash_info_out, cpu_run_out, op_grant_out, op_refuse_out;
    logic user_option_stale_out;
    logic [15:0] flash_addr_out, user_option_out;
    logic [255:0] trim_bytes_out, factory_bytes_out;
    region_t pm_region_out;
    logic [8:0] pm_info_offs_out;
    int n_errors = 0, total_checks = 0, cyc = 0;
    flash_protect_option_load dut_u (.clock_in, .rstn_in, .reg_req_in, .reg_rdata_out,
        .ctrl_state_in, .page_select_out, .protect_cfg_out, .stop_recover_in, .flash_rdata_in,
        .flash_rd_out, .flash_info_out, .flash_addr_out, .cpu_run_out, .user_option_out,
        .trim_bytes_out, .factory_bytes_out, .info_locked_in, .dbg_opt_wr_in, .dbg_opt_rd_in,
        .dbg_opt_idx_in, .dbg_opt_data_in, .dbg_opt_rdata_out, .pm_rd_in, .pm_addr_in,
        .pm_region_out, .pm_info_offs_out, .op_req_in, .op_grant_out, .op_refuse_out,
        .user_option_stale_out);
    flash_model fm_u (.rd_in(flash_rd_out), .info_in(flash_info_out), .addr_in(flash_addr_out),
        .data_out(flash_rdata_in));
    always #25 clock_in = ~clock_in;
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 1000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clock_in) reg_req_in = '{1'h1, 1'h0, a, d};
        @(negedge clock_in) reg_req_in = '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge clock_in) reg_req_in = '{1'h0, 1'h1, a, 8'h00};
        @(negedge clock_in) reg_req_in = '0;
        chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata_out});
    endtask
    task automatic opr(input op_kind_t k, input logic [15:0] a, input logic g);
        @(negedge clock_in) op_req_in = '{1'h1, k, a};
        @(negedge clock_in) op_req_in = '0;
        chk("grant", {15'h0, g}, {15'h0, op_grant_out});
        chk("refuse", {15'h0, ~g}, {15'h0, op_refuse_out});
    endtask
    task automatic pmr(input logic [15:0] a, input region_t r);
        @(negedge clock_in) {pm_rd_in, pm_addr_in} = {1'h1, a};
        @(negedge clock_in) pm_rd_in = 1'h0;
        chk("region", {13'h0, r}, {13'h0, pm_region_out});
        chk("offset", {7'h0, a[8:0]}, {7'h0, pm_info_offs_out});
    endtask
    task automatic dbg(input logic [7:0] d, input logic [7:0] e);
        @(negedge clock_in) {dbg_opt_wr_in, dbg_opt_data_in} = {1'h1, d};
        @(negedge clock_in) {dbg_opt_wr_in, dbg_opt_rd_in} = 2'h1;
        @(negedge clock_in) dbg_opt_rd_in = 1'h0;
        chk("dbg_rdata", {8'h00, e}, {8'h00, dbg_opt_rdata_out});
    endtask
    task automatic wait_run();
        for (int i = 0; i < 300 && cpu_run_out !== 1'h1; i++) @(negedge clock_in);
        chk("cpu_run", 16'h0001, {15'h0, cpu_run_out});
        chk("trim5", 16'h007f, {8'h00, trim_bytes_out[47:40]});
    endtask
    initial begin
        repeat (3) @(negedge clock_in);
        rstn_in = 1'h1;
        @(negedge clock_in);
        chk("cpu_run", 16'h0000, {15'h0, cpu_run_out});
        wait_run();
        chk("user_opt", 16'ha4a5, user_option_out);
        chk("fact3", 16'h0059, {8'h00, factory_bytes_out[31:24]});
        $display("test load done");
        wr(ADDR_CMD_STATUS, CMD_PROTECT_SEL);
        rd(ADDR_CMD_STATUS, 8'h04);
        rd(ADDR_PAGE_SHARED, 8'h00);
        wr(ADDR_PAGE_SHARED, 8'h45);
        rd(ADDR_PAGE_SHARED, 8'h05);
        wr(ADDR_PAGE_SHARED, 8'h84);
        wr(ADDR_PAGE_SHARED, 8'h02);
        rd(ADDR_PAGE_SHARED, 8'h86);
        chk("prot", 16'h0086, {8'h00, protect_cfg_out});
        chk("page_sel", 16'h0000, {8'h00, page_select_out});
        $display("test protect done");
        opr(OP_PROGRAM, 16'h0bff, 1'h0);
        opr(OP_PROGRAM, 16'h0c00, 1'h1);
        opr(OP_PAGE_ERASE, 16'h0000, 1'h0);
        opr(OP_MASS_ERASE, 16'h0000, 1'h1);
        wr(ADDR_CMD_STATUS, 8'h00);
        wr(ADDR_PAGE_SHARED, 8'hc3);
        rd(ADDR_PAGE_SHARED, 8'h83);
        opr(OP_PAGE_ERASE, 16'h0c00, 1'h0);
        ctrl_state_in = 3'h3;
        wr(ADDR_CMD_STATUS, CMD_PROTECT_SEL);
        rd(ADDR_CMD_STATUS, 8'h03);
        rd(ADDR_PAGE_SHARED, 8'h83);
        ctrl_state_in = 3'h0;
        chk("prot", 16'h0086, {8'h00, protect_cfg_out});
        chk("stale", 16'h0001, {15'h0, user_option_stale_out});
        chk("user_opt", 16'ha4a5, user_option_out);
        $display("test ops done");
        pmr(16'hfe1f, RGN_FACTORY);
        pmr(16'hfe57, RGN_DEVICE);
        pmr(16'hfe20, RGN_TRIM);
        pmr(16'hfe58, RGN_INFO_OTHER);
        rd(12'hff5, 8'h00);
        $display("test map done");
        wr(ADDR_TRIM_INDEX, 8'h05);
        wr(ADDR_TRIM_VALUE, 8'haa);
        rd(ADDR_TRIM_VALUE, 8'haa);
        chk("trim5", 16'h00aa, {8'h00, trim_bytes_out[47:40]});
        wr(ADDR_TRIM_INDEX, 8'h1f);
        rd(ADDR_TRIM_VALUE, 8'h65);
        $display("test trim done");
        dbg(8'h77, 8'h77);
        info_locked_in = 1'h1;
        dbg(8'h11, 8'h77);
        $display("test debug done");
        @(negedge clock_in) stop_recover_in = 1'h1;
        @(negedge clock_in) stop_recover_in = 1'h0;
        chk("cpu_run", 16'h0000, {15'h0, cpu_run_out});
        wait_run();
        chk("stale", 16'h0000, {15'h0, user_option_stale_out});
        $display("test reload done");
        close_out();
    end
endmodule
